// >>> include/ccs_pkg.sv
// Package with constants and types for the charge-control safety decoder
package ccs_pkg;

  // Clock rate and derived timing
  localparam int unsigned CLK_HZ        = 125_000_000;
  localparam int unsigned FAST_MS       = 32;     // Sample period with Ac_detected_bit
  localparam int unsigned SLOW_MS       = 250;    // Longest presence sample period without AC
  localparam int unsigned FULL_S        = 30;     // Longest full sweep period without AC
  localparam int unsigned TIMEOUT_MS    = 140000; // Request refresh timeout, plain default
  localparam int unsigned FAST_CYC      = FAST_MS * (CLK_HZ / 1000);
  localparam int unsigned SLOW_CYC      = SLOW_MS * (CLK_HZ / 1000);
  localparam int unsigned FULL_SLOWS    = (FULL_S * 1000) / SLOW_MS; // Slow ticks per full sweep
  localparam longint unsigned TIMEOUT_CYC = longint'(TIMEOUT_MS) * (CLK_HZ / 1000);
  localparam int unsigned SETTLE_CYC    = 16;     // Drive settle time before a comparison

  // Current ceilings in mA and step shifts per strap code
  localparam logic [15:0] CURRENT_CEILING_STRAP_0 = 16'h03ff;  // 1023 mA, 1 mA steps
  localparam logic [15:0] CURRENT_CEILING_STRAP_1 = 16'h07fe;  // 2046 mA, 2 mA steps
  localparam logic [15:0] CURRENT_CEILING_STRAP_2 = 16'h0bfc;  // 3068 mA, 4 mA steps
  localparam logic [15:0] CURRENT_CEILING_STRAP_3 = 16'h0ffc;  // 4092 mA, 4 mA steps
  localparam logic [1:0]  ISTEP_0 = 2'h0;
  localparam logic [1:0]  ISTEP_1 = 2'h1;
  localparam logic [1:0]  ISTEP_2 = 2'h2;
  localparam logic [1:0]  ISTEP_3 = 2'h2;

  // Voltage ceilings in mV, floor and step
  localparam logic [15:0] VOLTAGE_CEILING_STRAP_0 = 16'h1090;  // 4240 mV
  localparam logic [15:0] VOLTAGE_CEILING_STRAP_1 = 16'h10d0;  // 4304 mV
  localparam logic [15:0] VOLTAGE_CEILING_STRAP_2 = 16'h1150;  // 4432 mV
  localparam logic [15:0] VOLTAGE_CEILING_STRAP_3 = 16'h11a0;  // 4512 mV
  localparam logic [15:0] VOLTAGE_CEILING_STRAP_4 = 16'h1580;  // 5504 mV
  localparam logic [15:0] VOUT_FLOOR = 16'h0b54; // 2900 mV
  localparam logic [3:0]  VSTEP_MASK = 4'hf;     // 16 mV steps

  // Decoded safety-line range
  typedef enum logic [2:0]
  {
    RNG_UNDER = 3'h0,
    RNG_HOT   = 3'h1,
    RNG_IDEAL = 3'h2,
    RNG_COLD  = 3'h3,
    RNG_OVER  = 3'h4
  } ccs_range_t;

  // Sequencer states, one-hot
  typedef enum logic [4:0]
  {
    SQ_IDLE = 5'h01,
    SQ_DRV  = 5'h02,
    SQ_CMP  = 5'h04,
    SQ_DONE = 5'h08,
    SQ_OFF  = 5'h10
  } ccs_seq_t;

endpackage

// >>> include/ccs_sense_if.sv
// Interface between the decoder sequencer and the range sampler
`timescale 1ns/10ps
interface ccs_sense_if;
  logic       start;     // Begin a sweep
  logic       full;      // Full sweep, else presence only
  logic [2:0] prev;      // Previous range for hysteresis
  logic       done;      // Sweep finished, one cycle
  logic [2:0] range;     // Decoded range
  modport ctl (output start, output full, output prev, input done, input range);
  modport smp (input start, input full, input prev, output done, output range);
endinterface

// >>> logic/ccs_limit.sv
// Strap decoders that clamp the current and voltage requests
`timescale 1ns/10ps
module ccs_limit
(
  input  wire logic        clk,          // System clock
  input  wire logic        rst,          // Asynchronous reset
  input  wire logic [1:0]  i_strap,      // Current ceiling strap code
  input  wire logic [2:0]  v_strap,      // Voltage ceiling strap code
  input  wire logic [15:0] i_req,        // Stored current request
  input  wire logic [15:0] v_req,        // Stored voltage request
  output logic      [15:0] i_eff,        // Clamped current
  output logic      [15:0] v_eff,        // Clamped voltage
  output logic             v_over        // Voltage request above ceiling
);
  typedef struct packed
  {
    logic [15:0] i;
    logic [15:0] v;
    logic        vo;
  } ccs_lim_st_t;

  ccs_lim_st_t st_r;
  ccs_lim_st_t st_nxt;
  logic [15:0] ic;
  logic [15:0] vc;
  logic [1:0]  sh;
  logic [15:0] iq;

  // Ceiling selection, clamp and granularity
  always_comb
  begin
    case (i_strap)
      2'h0:    begin ic = ccs_pkg::CURRENT_CEILING_STRAP_0; sh = ccs_pkg::ISTEP_0; end
      2'h1:    begin ic = ccs_pkg::CURRENT_CEILING_STRAP_1; sh = ccs_pkg::ISTEP_1; end
      2'h2:    begin ic = ccs_pkg::CURRENT_CEILING_STRAP_2; sh = ccs_pkg::ISTEP_2; end
      default: begin ic = ccs_pkg::CURRENT_CEILING_STRAP_3; sh = ccs_pkg::ISTEP_3; end
    endcase
    case (v_strap)
      3'h0:    vc = ccs_pkg::VOLTAGE_CEILING_STRAP_0;
      3'h1:    vc = ccs_pkg::VOLTAGE_CEILING_STRAP_1;
      3'h2:    vc = ccs_pkg::VOLTAGE_CEILING_STRAP_2;
      3'h3:    vc = ccs_pkg::VOLTAGE_CEILING_STRAP_3;
      default: vc = ccs_pkg::VOLTAGE_CEILING_STRAP_4;
    endcase
    iq = (i_req > ic) ? ic : i_req;
    st_nxt.i  = (iq >> sh) << sh;
    st_nxt.vo = v_req > vc;
    st_nxt.v  = (v_req > vc) ? vc : (v_req & ~{12'h000, ccs_pkg::VSTEP_MASK});
  end

  // State register
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign i_eff  = st_r.i;
  assign v_eff  = st_r.v;
  assign v_over = st_r.vo;

  // Effective current never above the strap-0 ceiling while strap code 0 is held
  property p_iclamp;
    @(posedge clk) disable iff (rst)
      (i_strap == 2'h0 && $stable(i_strap)) |=> (i_eff <= ccs_pkg::CURRENT_CEILING_STRAP_0);
  endproperty
  iclamp_a: assert property (p_iclamp) else $error("current above ceiling");
  vclamp_a: assert property (@(posedge clk) disable iff (rst)
    (v_req > vc) |=> (v_over && v_eff == $past(vc))) else $error("voltage not clamped");
endmodule

// >>> logic/ccs_sampler.sv
// Threshold sweep of the safety line with hysteresis
`timescale 1ns/10ps
module ccs_sampler
(
  input  wire logic        clk,          // System clock
  input  wire logic        rst,          // Asynchronous reset
  ccs_sense_if.smp         sif,          // Sweep control
  input  wire logic        cmp_above,    // Sensed node above threshold
  output logic      [1:0]  thr_sel,      // Threshold under test
  output logic      [2:0]  thr_adj,      // Hysteresis hint: previous range
  output logic             low_drv,      // Drive low-value resistor side
  output logic             high_drv      // Drive high-value resistor side
);
  typedef struct packed
  {
    ccs_pkg::ccs_seq_t st;
    logic [1:0]  thr;
    logic [4:0]  cnt;
    logic [2:0]  rng;
    logic        full;
    logic        done;
  } ccs_smp_st_t;

  ccs_smp_st_t s_r;
  ccs_smp_st_t s_nxt;

  // Sweep: thresholds 0..3 from over/cold down to hot/under
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    case (s_r.st)
      ccs_pkg::SQ_IDLE:
      begin
        if (sif.start)
        begin
          s_nxt.st   = ccs_pkg::SQ_DRV;
          s_nxt.thr  = 2'h0;
          s_nxt.full = sif.full;
          s_nxt.cnt  = '0;
        end
      end
      ccs_pkg::SQ_DRV:
      begin
        s_nxt.cnt = s_r.cnt + 5'h01;
        if (s_r.cnt == 5'(ccs_pkg::SETTLE_CYC - 1))
          s_nxt.st = ccs_pkg::SQ_CMP;
      end
      ccs_pkg::SQ_CMP:
      begin
        s_nxt.cnt = '0;
        if (cmp_above)
        begin
          s_nxt.rng = 3'(3'h4 - {1'b0, s_r.thr});
          s_nxt.st  = ccs_pkg::SQ_DONE;
        end
        else if (s_r.thr == 2'h3)
        begin
          s_nxt.rng = 3'h0;
          s_nxt.st  = ccs_pkg::SQ_DONE;
        end
        else if (!s_r.full)
        begin
          s_nxt.rng = 3'h2;
          s_nxt.st  = ccs_pkg::SQ_DONE;
        end
        else
        begin
          s_nxt.thr = s_r.thr + 2'h1;
          s_nxt.st  = ccs_pkg::SQ_DRV;
        end
      end
      ccs_pkg::SQ_DONE:
      begin
        s_nxt.done = 1'b1;
        s_nxt.st   = ccs_pkg::SQ_IDLE;
      end
      default: s_nxt.st = ccs_pkg::SQ_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      s_r <= '{st: ccs_pkg::SQ_IDLE, rng: 3'h4, default: '0};
    else
      s_r <= s_nxt;
  end

  wire active = (s_r.st == ccs_pkg::SQ_DRV) || (s_r.st == ccs_pkg::SQ_CMP);
  assign thr_sel   = s_r.thr;
  assign thr_adj   = sif.prev;
  assign high_drv  = active && !s_r.thr[1];
  assign low_drv   = active && s_r.thr[1];
  assign sif.done  = s_r.done;
  assign sif.range = s_r.rng;

  drv_a: assert property (@(posedge clk) disable iff (rst)
    !(low_drv && high_drv)) else $error("both sides driven");
  order_a: assert property (@(posedge clk) disable iff (rst)
    (s_r.st == ccs_pkg::SQ_CMP && !cmp_above && s_r.full && s_r.thr != 2'h3)
      |=> (thr_sel == $past(thr_sel) + 2'h1)) else $error("threshold order");
endmodule

// >>> logic/ccs_ctrl.sv
// Charge-control decision logic with safety-line decoder and limits
`timescale 1ns/10ps
module ccs_ctrl
#(
  parameter longint unsigned TIMEOUT_CYC = ccs_pkg::TIMEOUT_CYC, // Request timeout
  parameter int unsigned     FAST_CYC    = ccs_pkg::FAST_CYC,    // AC sample period
  parameter int unsigned     SLOW_CYC    = ccs_pkg::SLOW_CYC,    // No-AC sample period
  parameter int unsigned     FULL_SLOWS  = ccs_pkg::FULL_SLOWS   // Slow ticks per full sweep
)
(
  input  wire logic        clk,               // System clock
  input  wire logic        rst,               // Asynchronous reset
  input  wire logic        voltage_wr,        // Voltage request write strobe
  input  wire logic        current_wr,        // Current request write strobe
  input  wire logic [15:0] wr_data,           // Written request value
  input  wire logic        inhibit_bit,       // Inhibit-charge mode bit
  input  wire logic        clear_requests_bit,// Clear_requests_bit mode bit
  input  wire logic        alarm_block_bit,   // Alarm_block_bit status
  input  wire logic        ac_detected_bit,   // Divided input above threshold
  input  wire logic        charge_enable_pin, // External enable, low stops
  input  wire logic        supply_ok,         // Input supply sufficient
  input  wire logic        cmp_above,         // Safety-line comparator
  input  wire logic [1:0]  current_ceiling_strap, // Current strap code
  input  wire logic [2:0]  voltage_ceiling_strap, // Voltage strap code
  output logic             charge_en,         // Charger output enable
  output logic      [15:0] voltage_out,       // Clamped voltage setting
  output logic      [15:0] current_out,       // Clamped current setting
  output logic             voltage_over_bit,  // Voltage request over ceiling
  output logic             range_underrange_bit, // Underrange status
  output logic             range_hot_bit,     // Hot status
  output logic             range_cold_bit,    // Cold status
  output logic             range_overrange_bit,  // Overrange status
  output logic             battery_present_bit,  // Presence status
  output logic      [1:0]  thr_sel,           // Threshold under test
  output logic      [2:0]  thr_adj,           // Hysteresis hint
  output logic             low_res_drive_sel, // Drive low-value side
  output logic             high_res_drive_sel,// Drive high-value side
  output logic             alert_line_n       // Alert, active low
);
  initial
  begin
    if (TIMEOUT_CYC < 1 || FAST_CYC < 64 || SLOW_CYC < 64 || FULL_SLOWS < 1)
      $error("ccs_ctrl: bad timing parameter");
  end

  typedef struct packed
  {
    logic [15:0] vreq;
    logic [15:0] ireq;
    logic        vwr;
    logic        iwr;
    logic [39:0] tmo;
    logic        run;
    logic [31:0] per;
    logic [15:0] slows;
    logic        busy;
    logic        start;
    logic        full;
    logic [2:0]  rng;
    logic [4:0]  stat;
    logic        ac_d;
    logic        pres_d;
    logic        alm_d;
    logic        alert;
    logic        first;
  } ccs_ctl_st_t;

  ccs_ctl_st_t st_r;
  ccs_ctl_st_t st_nxt;
  ccs_sense_if sif ();
  logic        range_ok;
  logic        stop_now;
  logic        tmo_hit;
  logic [15:0] i_eff;
  logic [15:0] v_eff;
  logic        v_over;

  // Request clamp and strap decode
  ccs_limit u_limit
  (
    .clk     (clk),
    .rst     (rst),
    .i_strap (current_ceiling_strap),
    .v_strap (voltage_ceiling_strap),
    .i_req   (st_r.vreq == 16'h0000 ? 16'h0000 : st_r.ireq),
    .v_req   (st_r.vreq),
    .i_eff   (i_eff),
    .v_eff   (v_eff),
    .v_over  (v_over)
  );

  // Threshold sweep
  ccs_sampler u_sampler
  (
    .clk       (clk),
    .rst       (rst),
    .sif       (sif.smp),
    .cmp_above (cmp_above),
    .thr_sel   (thr_sel),
    .thr_adj   (thr_adj),
    .low_drv   (low_res_drive_sel),
    .high_drv  (high_res_drive_sel)
  );

  assign sif.start = st_r.start;
  assign sif.full  = st_r.full;
  assign sif.prev  = st_r.rng;

  // Charging qualifiers, evaluated every cycle
  assign range_ok = (st_r.rng == ccs_pkg::RNG_COLD) || (st_r.rng == ccs_pkg::RNG_IDEAL)
                 || (st_r.rng == ccs_pkg::RNG_UNDER);
  assign tmo_hit  = (st_r.tmo >= 40'(TIMEOUT_CYC));
  assign stop_now = !range_ok || !ac_detected_bit || alarm_block_bit
                 || inhibit_bit || clear_requests_bit
                 || !charge_enable_pin || !supply_ok
                 || tmo_hit || (st_r.vreq == 16'h0000) || (st_r.ireq == 16'h0000);

  // Next-state logic
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.start = 1'b0;
    // Request storage; stored values survive stops other than clear_requests_bit for later resume
    if (voltage_wr)
    begin
      st_nxt.vreq = wr_data;
      st_nxt.vwr  = 1'b1;
    end
    if (current_wr)
    begin
      st_nxt.ireq = wr_data;
      st_nxt.iwr  = 1'b1;
    end
    if (clear_requests_bit)
    begin
      st_nxt.vreq = 16'h0000;
      st_nxt.ireq = 16'h0000;
    end
    // Refresh timeout restarts when either request is rewritten
    if (voltage_wr || current_wr)
      st_nxt.tmo = '0;
    else if (!tmo_hit)
      st_nxt.tmo = st_r.tmo + 40'h1;
    // Controlled charging begins once both requests written
    if (st_r.vwr && st_r.iwr)
      st_nxt.run = 1'b1;
    if (st_nxt.vreq == 16'h0000 || st_nxt.ireq == 16'h0000)
      st_nxt.run = 1'b0;
    // Sample scheduler: fast with AC, slow without
    if (st_r.per == 32'h0)
    begin
      st_nxt.per   = ac_detected_bit ? 32'(FAST_CYC - 1) : 32'(SLOW_CYC - 1);
      st_nxt.start = !st_r.busy;
      st_nxt.busy  = 1'b1;
      if (ac_detected_bit || st_r.slows == 16'h0)
      begin
        st_nxt.full  = 1'b1;
        st_nxt.slows = 16'(FULL_SLOWS - 1);
      end
      else
      begin
        st_nxt.full  = 1'b0;
        st_nxt.slows = st_r.slows - 16'h1;
      end
    end
    else
      st_nxt.per = st_r.per - 32'h1;
    // Sweep result; a presence-only sweep keeps prior temperature bits unless it or the prior range is overrange
    if (sif.done)
    begin
      st_nxt.busy = 1'b0;
      if (st_r.full || sif.range == ccs_pkg::RNG_OVER || st_r.rng == ccs_pkg::RNG_OVER)
        st_nxt.rng = sif.range;
      case (st_nxt.rng)
        ccs_pkg::RNG_UNDER: st_nxt.stat = 5'b11001;
        ccs_pkg::RNG_HOT:   st_nxt.stat = 5'b01001;
        ccs_pkg::RNG_IDEAL: st_nxt.stat = 5'b00001;
        ccs_pkg::RNG_COLD:  st_nxt.stat = 5'b00101;
        default:            st_nxt.stat = 5'b00110;
      endcase
    end
    // Alert on AC or presence changes, alarm-block rising, or power-on
    st_nxt.ac_d   = ac_detected_bit;
    st_nxt.pres_d = st_nxt.stat[0];
    st_nxt.alm_d  = alarm_block_bit;
    st_nxt.first  = 1'b0;
    if (st_r.first || (ac_detected_bit != st_r.ac_d) || (st_nxt.stat[0] != st_r.pres_d)
        || (alarm_block_bit && !st_r.alm_d))
      st_nxt.alert = 1'b1;
  end

  // State register
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      st_r <= '{rng: 3'h4, stat: 5'b00110, first: 1'b1, default: '0};
    else
      st_r <= st_nxt;
  end

  // Charger enable register: drops the cycle after stop is seen
  logic en_r;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      en_r <= 1'b0;
    else
      en_r <= st_r.run && !stop_now;
  end

  // Output registers
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      voltage_out      <= 16'h0000;
      current_out      <= 16'h0000;
      voltage_over_bit <= 1'b0;
      alert_line_n     <= 1'b1;
    end
    else
    begin
      voltage_out      <= v_eff;
      current_out      <= i_eff;
      voltage_over_bit <= v_over;
      alert_line_n     <= !st_r.alert;
    end
  end

  assign charge_en            = en_r;
  assign range_underrange_bit = st_r.stat[4];
  assign range_hot_bit        = st_r.stat[3];
  assign range_cold_bit       = st_r.stat[2];
  assign range_overrange_bit  = st_r.stat[1];
  assign battery_present_bit  = st_r.stat[0];

  stop_a: assert property (@(posedge clk) disable iff (rst)
    stop_now |=> !charge_en) else $error("charging while stopped");
  hot_stop_a: assert property (@(posedge clk) disable iff (rst)
    (range_hot_bit && !range_underrange_bit) |=> !charge_en) else $error("charging when hot");
  ac_stop_a: assert property (@(posedge clk) disable iff (rst)
    $fell(ac_detected_bit) |=> !charge_en) else $error("charging without AC");
  pin_stop_a: assert property (@(posedge clk) disable iff (rst)
    !charge_enable_pin |=> !charge_en) else $error("charging with pin low");
  zero_wr_a: assert property (@(posedge clk) disable iff (rst)
    (voltage_wr && wr_data == 16'h0000) |=> ##1 !charge_en) else $error("zero write");
  over_bits_a: assert property (@(posedge clk) disable iff (rst)
    range_overrange_bit |-> (range_cold_bit && !battery_present_bit)) else $error("bits");
  alert_chg_a: assert property (@(posedge clk) disable iff (rst)
    (ac_detected_bit != $past(ac_detected_bit)) |=> ##1 !alert_line_n) else $error("alert");
endmodule

// >>> dv/ccs_batt_model.sv
// Battery safety-line model answering the sweep comparator
`timescale 1ns/10ps
module ccs_batt_model
(
  input  wire logic       clk,       // System clock
  input  wire logic [2:0] rng,       // Range the battery presents
  input  wire logic [1:0] thr_sel,   // Threshold under test
  input  wire logic       low_drv,   // Low-value side driven
  input  wire logic       high_drv,  // High-value side driven
  output logic            cmp_above  // Comparator result
);
  initial cmp_above = 1'b0;
  // Answer only while the proper side is driven; otherwise the node wanders
  always @(posedge clk)
  begin
    if ((thr_sel < 2'h2) ? (high_drv && !low_drv) : (low_drv && !high_drv))
      cmp_above <= ({1'b0, rng} >= (4'h4 - {2'h0, thr_sel}));
    else
      cmp_above <= ~cmp_above;
  end
endmodule

// >>> dv/ccs_ctrl_tb_top.sv
// Self-checking bench for the charge-control decision block
`timescale 1ns/10ps
module ccs_ctrl_tb_top;
  logic        clk, rst, vwr, iwr, inh, clr, alm, ac, en, sok, cmp;
  logic [15:0] wd, vo, co;
  logic [1:0]  is, ts;
  logic [2:0]  vs, rng, ta;
  logic        chg, vov, ur, hot, cold, ovr, pres, ld, hd, al_n;
  logic [15:0] il [4];
  logic [15:0] vl [5];
  logic [4:0]  st [5];
  int          mismatches;
  int          checked;

  ccs_ctrl #(.TIMEOUT_CYC(2000), .FAST_CYC(200), .SLOW_CYC(400), .FULL_SLOWS(3)) ccs_ctrl_i
  (
    .clk(clk), .rst(rst), .voltage_wr(vwr), .current_wr(iwr), .wr_data(wd),
    .inhibit_bit(inh), .clear_requests_bit(clr), .alarm_block_bit(alm),
    .ac_detected_bit(ac), .charge_enable_pin(en), .supply_ok(sok), .cmp_above(cmp),
    .current_ceiling_strap(is), .voltage_ceiling_strap(vs), .charge_en(chg),
    .voltage_out(vo), .current_out(co), .voltage_over_bit(vov),
    .range_underrange_bit(ur), .range_hot_bit(hot), .range_cold_bit(cold),
    .range_overrange_bit(ovr), .battery_present_bit(pres), .thr_sel(ts), .thr_adj(ta),
    .low_res_drive_sel(ld), .high_res_drive_sel(hd), .alert_line_n(al_n)
  );

  ccs_batt_model ccs_batt_model_i
  (
    .clk(clk), .rng(rng), .thr_sel(ts), .low_drv(ld), .high_drv(hd), .cmp_above(cmp)
  );

  // Clock generator
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Voltage then current request, one strobe each
  task automatic wr(input logic [15:0] v, input logic [15:0] i);
    @(posedge clk);
    vwr <= 1'b1;
    wd  <= v;
    @(posedge clk);
    vwr <= 1'b0;
    iwr <= 1'b1;
    wd  <= i;
    @(posedge clk);
    iwr <= 1'b0;
    cyc(5);
  endtask

  // Raise or drop one stop qualifier
  task automatic stop_set(input int k, input logic bad);
    @(posedge clk);
    case (k)
      0: inh <= bad;
      1: en  <= ~bad;
      2: sok <= ~bad;
      3: alm <= bad;
      default: ac <= ~bad;
    endcase
  endtask

  task automatic close_out;
    if (mismatches == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Watchdog against a hung run
  initial
  begin
    repeat (40000) @(posedge clk);
    mismatches++;
    close_out();
  end

  // Main test sequence
  initial
  begin
    il = '{ccs_pkg::CURRENT_CEILING_STRAP_0, ccs_pkg::CURRENT_CEILING_STRAP_1, ccs_pkg::CURRENT_CEILING_STRAP_2, ccs_pkg::CURRENT_CEILING_STRAP_3};
    vl = '{ccs_pkg::VOLTAGE_CEILING_STRAP_0, ccs_pkg::VOLTAGE_CEILING_STRAP_1, ccs_pkg::VOLTAGE_CEILING_STRAP_2, ccs_pkg::VOLTAGE_CEILING_STRAP_3, ccs_pkg::VOLTAGE_CEILING_STRAP_4};
    st = '{5'h19, 5'h09, 5'h01, 5'h05, 5'h06};
    mismatches = 0;
    checked = 0;
    rst = 1'b1;
    {vwr, iwr, inh, clr, alm} = 5'h00;
    {ac, en, sok} = 3'h7;
    wd = 16'h0000;
    is = 2'h0;
    vs = 3'h0;
    rng = 3'h2;
    cyc(15);
    chk("status", 16'h0006, {ur, hot, cold, ovr, pres});
    chk("charge", 16'h0000, chg);
    @(posedge clk) rst <= 1'b0;
    cyc(4);
    chk("alert", 16'h0000, al_n);
    for (int r = 0; r < 5; r++)
    begin
      @(posedge clk) rng <= r[2:0];
      cyc(400);
      chk("status", {11'h000, st[r]}, {ur, hot, cold, ovr, pres});
      chk("thr_adj", {13'h0000, r[2:0]}, ta);
      chk("charge", 16'h0000, chg);
    end
    @(posedge clk) rng <= 3'h2;
    cyc(400);
    wr(16'h1000, 16'h0100);
    chk("charge", 16'h0001, chg);
    chk("current", 16'h0100, co);
    for (int s = 0; s < 4; s++)
    begin
      @(posedge clk) is <= s[1:0];
      wr(16'h1000, 16'hffff);
      chk("current", il[s], co);
    end
    wr(16'h1000, 16'h0103);
    chk("current", 16'h0100, co);
    for (int s = 0; s < 5; s++)
    begin
      @(posedge clk) vs <= s[2:0];
      wr(16'hffff, 16'h0100);
      chk("voltage", vl[s], vo);
      chk("vover", 16'h0001, vov);
    end
    wr(16'h1008, 16'h0100);
    chk("voltage", 16'h1000, vo);
    chk("vover", 16'h0000, vov);
    for (int k = 0; k < 5; k++)
    begin
      wr(16'h1000, 16'h0100);
      stop_set(k, 1'b1);
      cyc(2);
      chk("charge", 16'h0000, chg);
      stop_set(k, 1'b0);
      cyc(5);
      if (k < 3)
        chk("charge", 16'h0001, chg);
      cyc(400);
    end
    wr(16'h1000, 16'h0100);
    chk("charge", 16'h0001, chg);
    for (int k = 0; k < 2; k++)
    begin
      @(posedge clk) rng <= (k == 0) ? 3'h1 : 3'h4;
      cyc(350);
      chk("charge", 16'h0000, chg);
      @(posedge clk) rng <= 3'h2;
      cyc(350);
      wr(16'h1000, 16'h0100);
    end
    wr(16'h1000, 16'h0000);
    chk("charge", 16'h0000, chg);
    wr(16'h1000, 16'h0100);
    chk("charge", 16'h0001, chg);
    @(posedge clk) clr <= 1'b1;
    cyc(3);
    chk("charge", 16'h0000, chg);
    @(posedge clk) clr <= 1'b0;
    wr(16'h1000, 16'h0100);
    cyc(1500);
    chk("charge", 16'h0001, chg);
    cyc(600);
    chk("charge", 16'h0000, chg);
    // Without AC: presence-only sweeps, full sweep on the slow schedule
    @(posedge clk)
    begin
      ac  <= 1'b0;
      rng <= 3'h4;
    end
    cyc(450);
    chk("status", 16'h0006, {ur, hot, cold, ovr, pres});
    @(posedge clk) rng <= 3'h1;
    cyc(1700);
    chk("status", 16'h0009, {ur, hot, cold, ovr, pres});
    chk("charge", 16'h0000, chg);
    close_out();
  end
endmodule
